// ### src/osc_ctl_cfg.svh
// offsets, field positions, reset values and timing counts of the oscillator control block
// assumes inclusion by bare name from the package and the modules
`ifndef OSC_CTL_CFG_SVH
`define OSC_CTL_CFG_SVH

// ************************************************************
// register offsets (word index on the plain port)
// ************************************************************
`define OFS_OSC_CONTROL 4'h0
`define OFS_CLOCK_DIVIDER 4'h1
`define OFS_FAST_RC_TRIM 4'h2
`define OFS_IRQ_STATUS 4'h3
`define OFS_IRQ_MASK 4'h4

// ************************************************************
// oscillator control field positions
// ************************************************************
`define CUR_SRC_LSB 12
`define REQ_SRC_LSB 8
`define FREEZE_BIT 7
`define LOCK_BIT 5
`define FAIL_BIT 3
`define SECONDARY_OSC_DRIVE_BIT 2
`define SECONDARY_OSC_ENABLE_BIT 1
`define SWITCH_REQ_BIT 0

// ************************************************************
// reset values and widths
// ************************************************************
`define CLOCK_DIVIDER_RESET 16'h3100
`define FAST_RC_TRIM_RESET 6'h00
`define FAST_RC_TRIM_WIDTH 6
`define IRQ_BITS 3

// ************************************************************
// timing: oscillator settle before a switch completes
// ************************************************************
`define SETTLE_TIME_NS 256
`define CLK_PERIOD_NS 4
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### src/osc_ctl_pkg.sv
// types shared by the oscillator control modules
// assumes the cfg header sits on the include path
package osc_ctl_pkg;
  `include "osc_ctl_cfg.svh"

  // ************************************************************
  // clock source encoding
  // ************************************************************
  typedef enum logic [2:0] {
    SRC_FAST_RC = 3'h0, // 8 MHz fast rc
    SRC_FAST_RC_MULT = 3'h1, // fast rc, postscaler and pll
    SRC_PRIMARY = 3'h2, // primary oscillator
    SRC_PRIMARY_PLL = 3'h3, // primary with pll
    SRC_SECONDARY = 3'h4, // secondary oscillator
    SRC_LOW_POWER_RC = 3'h5, // low-power rc
    SRC_SLOW_FAST_RC_DIV = 3'h6, // 500 kHz fast rc with postscaler
    SRC_FAST_RC_DIV = 3'h7 // 8 MHz fast rc with postscaler
  } clk_src_type;

  // switch sequencer states
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_SETTLE,
    SW_COMMIT
  } switch_state_type;

  // pll mode test
  function automatic logic src_uses_pll(input clk_src_type s);
    src_uses_pll = (s == SRC_FAST_RC_MULT) || (s == SRC_PRIMARY_PLL);
  endfunction : src_uses_pll
endpackage : osc_ctl_pkg

// ### src/osc_lock_sync.sv
// two-flop synchroniser for the asynchronous oscillator status inputs
// assumes the inputs are slow levels
`timescale 1ns/1ps
module osc_lock_sync #(
  parameter int WIDTH = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] meta; // first stage, read only by second
    logic [WIDTH-1:0] sync;
  } sync_state_type;

  sync_state_type s_q, s_d;

  // shift chain
  always_comb begin
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
  end

  // stages
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.sync;
endmodule : osc_lock_sync

// ### src/osc_select_ctl.sv
// oscillator select control: control, divider and trim registers plus switch flow
// assumes a plain register port on the system clock, status pins from the analog side
`timescale 1ns/1ps
`include "osc_ctl_cfg.svh"
module osc_select_ctl
  import osc_ctl_pkg::*;
#(
  parameter int SETTLE = `SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [2:0] i_boot_source_config,
  input wire logic i_pll_locked,
  input wire logic i_clock_fail,
  input wire logic i_secondary_osc_source,
  input wire logic i_freeze_hw_set,
  input wire logic i_freeze_hw_clr,
  output logic [15:0] o_rdata,
  output logic o_irq,
  output logic [2:0] o_clk_mux_sel,
  output logic o_secondary_osc_run,
  output logic o_secondary_osc_high_drive,
  output logic [15:0] o_clock_divider_reg,
  output logic [5:0] o_fast_rc_trim_reg
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic boot_done; // boot source captured after reset release
    clk_src_type current_source_sel; // source driving the system clock
    clk_src_type requested_source_sel; // target of next switch
    logic switch_freeze; // blocks further switches
    logic pll_lock; // lock status as seen by software
    logic clock_fail_flag; // sticky failure flag
    logic secondary_osc_drive; // high drive for crystal
    logic secondary_osc_enable; // keep secondary running
    logic high_drive; // drive as applied, only with a crystal
    logic switch_request; // switch in progress
    logic switch_pending; // start pulse still to issue
    logic [15:0] clock_divider_reg; // doze and postscaler
    logic [5:0] fast_rc_trim_reg; // signed fast rc trim
    logic [2:0] irq_status; // sticky: done, fail, lock lost
    logic [2:0] irq_mask; // enables for irq_status
    logic irq; // registered interrupt level
    logic lock_prev; // last synchronised lock value
    logic [15:0] rdata; // read data register
  } ctl_state_type;

  ctl_state_type s_q, s_d;

  logic [2:0] status_sync; // synchronised lock, fail and secondary source
  logic [15:0] ctl_view; // control register as read
  logic [2:0] irq_events; // this cycle's events

  osc_switch_if sw ();

  // ************************************************************
  // submodules
  // ************************************************************
  // asynchronous analog status must pass two flops
  osc_lock_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_secondary_osc_source, i_clock_fail, i_pll_locked}),
    .o_sync(status_sync)
  );

  // settle timer for the mux changeover
  osc_switch_seq #(
    .SETTLE(SETTLE)
  ) u_seq (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .sw(sw)
  );

  assign sw.start = s_q.switch_pending;
  assign sw.target = s_q.requested_source_sel;

  // ************************************************************
  // control register view
  // ************************************************************
  // bits 15, 11, 6, 4 are tied to zero
  always_comb begin
    ctl_view = 16'h0000;
    ctl_view[`CUR_SRC_LSB +: 3] = s_q.current_source_sel;
    ctl_view[`REQ_SRC_LSB +: 3] = s_q.requested_source_sel;
    ctl_view[`FREEZE_BIT] = s_q.switch_freeze;
    ctl_view[`LOCK_BIT] = s_q.pll_lock;
    ctl_view[`FAIL_BIT] = s_q.clock_fail_flag;
    ctl_view[`SECONDARY_OSC_DRIVE_BIT] = s_q.secondary_osc_drive;
    ctl_view[`SECONDARY_OSC_ENABLE_BIT] = s_q.secondary_osc_enable;
    ctl_view[`SWITCH_REQ_BIT] = s_q.switch_request;
  end

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.switch_pending = 1'b0;
    irq_events = 3'h0;

    // boot source taken at the first edge after reset release
    if (!s_q.boot_done) begin
      s_d.boot_done = 1'b1;
      s_d.requested_source_sel = clk_src_type'(i_boot_source_config);
      s_d.current_source_sel = clk_src_type'(i_boot_source_config);
    end

    // hardware clear first, so any set in the same cycle wins
    if (i_freeze_hw_clr) begin
      s_d.switch_freeze = 1'b0;
    end

    // software writes
    if (i_wr) begin
      case (i_addr)
        `OFS_OSC_CONTROL: begin
          s_d.requested_source_sel = clk_src_type'(i_wdata[`REQ_SRC_LSB +: 3]);
          if (i_wdata[`FREEZE_BIT]) begin
            s_d.switch_freeze = 1'b1; // software may only set
          end
          if (!i_wdata[`FAIL_BIT]) begin
            s_d.clock_fail_flag = 1'b0; // software may only clear
          end
          s_d.secondary_osc_drive = i_wdata[`SECONDARY_OSC_DRIVE_BIT];
          s_d.secondary_osc_enable = i_wdata[`SECONDARY_OSC_ENABLE_BIT];
          // start a switch unless frozen or one is running
          if (i_wdata[`SWITCH_REQ_BIT] && !s_q.switch_request && !s_q.switch_freeze && !sw.busy) begin
            s_d.switch_request = 1'b1;
            s_d.switch_pending = 1'b1;
          end
        end
        `OFS_CLOCK_DIVIDER: begin
          s_d.clock_divider_reg = i_wdata;
        end
        `OFS_FAST_RC_TRIM: begin
          s_d.fast_rc_trim_reg = i_wdata[`FAST_RC_TRIM_WIDTH-1:0];
        end
        `OFS_IRQ_MASK: begin
          s_d.irq_mask = i_wdata[`IRQ_BITS-1:0];
        end
        default: begin
          // unmapped or read-only: write ignored
        end
      endcase
    end

    // hardware set of the freeze bit, after every clear
    if (i_freeze_hw_set) begin
      s_d.switch_freeze = 1'b1;
    end

    // failure detect wins over a software clear
    if (status_sync[1]) begin
      s_d.clock_fail_flag = 1'b1;
      irq_events[1] = !s_q.clock_fail_flag;
    end

    // switch completion updates the current source
    if (sw.done) begin
      s_d.current_source_sel = s_q.requested_source_sel;
      s_d.switch_request = 1'b0;
      irq_events[0] = 1'b1;
    end

    // lock follows pll only in pll modes, held low while switching
    if (s_q.switch_request || !src_uses_pll(s_q.current_source_sel)) begin
      s_d.pll_lock = 1'b0;
    end else begin
      s_d.pll_lock = status_sync[0];
    end
    s_d.lock_prev = status_sync[0];
    // drive reaches the pin only with a crystal; a digital input ignores it
    s_d.high_drive = s_d.secondary_osc_drive && status_sync[2];
    irq_events[2] = s_q.lock_prev && !status_sync[0] && src_uses_pll(s_q.current_source_sel);

    // read data, one cycle after the strobe
    s_d.rdata = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        `OFS_OSC_CONTROL: s_d.rdata = ctl_view;
        `OFS_CLOCK_DIVIDER: s_d.rdata = s_q.clock_divider_reg;
        `OFS_FAST_RC_TRIM: s_d.rdata = {10'h000, s_q.fast_rc_trim_reg};
        `OFS_IRQ_STATUS: s_d.rdata = {13'h0000, s_q.irq_status};
        `OFS_IRQ_MASK: s_d.rdata = {13'h0000, s_q.irq_mask};
        default: s_d.rdata = 16'h0000; // unmapped reads zero
      endcase
    end

    // sticky status: read clears, a same-cycle event survives
    if (i_rd && i_addr == `OFS_IRQ_STATUS) begin
      s_d.irq_status = irq_events;
    end else begin
      s_d.irq_status = s_q.irq_status | irq_events;
    end
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '{
        boot_done: 1'b0,
        current_source_sel: SRC_FAST_RC,
        requested_source_sel: SRC_FAST_RC,
        switch_freeze: 1'b0,
        pll_lock: 1'b0,
        clock_fail_flag: 1'b0,
        secondary_osc_drive: 1'b0,
        secondary_osc_enable: 1'b0,
        high_drive: 1'b0,
        switch_request: 1'b0,
        switch_pending: 1'b0,
        clock_divider_reg: `CLOCK_DIVIDER_RESET,
        fast_rc_trim_reg: `FAST_RC_TRIM_RESET,
        irq_status: 3'h0,
        irq_mask: 3'h0,
        irq: 1'b0,
        lock_prev: 1'b0,
        rdata: 16'h0000
      };
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs, all from flops
  // ************************************************************
  assign o_rdata = s_q.rdata;
  assign o_irq = s_q.irq;
  assign o_clk_mux_sel = s_q.current_source_sel;
  // kept running while enabled; selection itself goes through the mux
  assign o_secondary_osc_run = s_q.secondary_osc_enable;
  // drive is inert with a digital clock input
  assign o_secondary_osc_high_drive = s_q.high_drive;
  assign o_clock_divider_reg = s_q.clock_divider_reg;
  assign o_fast_rc_trim_reg = s_q.fast_rc_trim_reg;
endmodule : osc_select_ctl

// ### src/osc_switch_if.sv
// carrier between the register front and the switch sequencer
// assumes both ends run on the one system clock
`timescale 1ns/1ps
interface osc_switch_if;
  import osc_ctl_pkg::*;
  logic start; // one-cycle request to switch
  clk_src_type target; // requested source
  logic busy; // sequence in progress
  logic done; // one-cycle completion pulse
  modport ctl (output start, output target, input busy, input done);
  modport seq (input start, input target, output busy, output done);
endinterface : osc_switch_if

// ### src/osc_switch_seq.sv
// switch sequencer: waits for the new source to settle, then reports done
// assumes the settle count fits the counter width
`timescale 1ns/1ps
`include "osc_ctl_cfg.svh"
module osc_switch_seq
  import osc_ctl_pkg::*;
#(
  parameter int SETTLE = `SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  osc_switch_if.seq sw
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    switch_state_type st;
    logic [15:0] cnt;
    logic busy;
    logic done;
  } seq_state_type;

  seq_state_type s_q, s_d;

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      SW_IDLE: begin
        if (sw.start) begin // begin waiting on the new source
          s_d.st = SW_SETTLE;
          s_d.cnt = 16'(SETTLE);
          s_d.busy = 1'b1;
        end
      end
      SW_SETTLE: begin
        if (s_q.cnt <= 16'h0001) begin
          s_d.st = SW_COMMIT;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      SW_COMMIT: begin // settle over; done pulses next, and the mux changes over when done is seen
        s_d.st = SW_IDLE;
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      default: begin
        s_d.st = SW_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '{st: SW_IDLE, cnt: 16'h0000, busy: 1'b0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sw.busy = s_q.busy;
  assign sw.done = s_q.done;
endmodule : osc_switch_seq

// ### verif/osc_analog_model.sv
// far-side model: pll lock, clock fail detector and secondary source pin
// assumes o_clk_mux_sel shows which source is running
`timescale 1ns/1ps
module osc_analog_model #(
  parameter int LOCK_DELAY = 6 // cycles for the pll to lock
) (
  input wire logic i_clk,
  input wire logic [2:0] i_mux_sel,
  input wire logic i_fail_inject,
  input wire logic i_crystal,
  output logic o_pll_locked,
  output logic o_clock_fail,
  output logic o_secondary_osc_source
);
  int lock_cnt = 0; // cycles spent in a pll mode
  // lock only after a pll mode has run a while; leaving it drops lock at the next edge
  always @(posedge i_clk) begin
    if (i_mux_sel == 3'h1 || i_mux_sel == 3'h3) begin
      if (lock_cnt < LOCK_DELAY) begin
        lock_cnt <= lock_cnt + 1;
      end
    end else begin
      lock_cnt <= 0;
    end
  end
  assign o_pll_locked = (lock_cnt >= LOCK_DELAY);
  assign o_clock_fail = i_fail_inject; // detector level follows the fault
  assign o_secondary_osc_source = i_crystal; // 0: digital clock in, so drive is inert
endmodule : osc_analog_model

// ### verif/osc_select_ctl_props.sv
// port checker for the oscillator select block
// assumes it is bound onto osc_select_ctl
`timescale 1ns/1ps
`include "osc_ctl_cfg.svh"
module osc_select_ctl_props #(
  parameter int SETTLE = 2 // settle count of the bound design
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_secondary_osc_source,
  input wire logic [15:0] o_rdata,
  input wire logic o_irq,
  input wire logic [2:0] o_clk_mux_sel,
  input wire logic o_secondary_osc_run,
  input wire logic o_secondary_osc_high_drive,
  input wire logic [15:0] o_clock_divider_reg,
  input wire logic [5:0] o_fast_rc_trim_reg
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ********
  // read port
  // ********
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  chk_unmapped_zero: assert property (i_rd && i_addr > 4'h4 |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_ctl_reserved: assert property (i_rd && i_addr == `OFS_OSC_CONTROL |=>
    !o_rdata[15] && !o_rdata[11] && !o_rdata[6] && !o_rdata[4]) else $error("reserved bit set");
  // lock can only read high while a pll mode runs
  chk_lock_non_pll: assert property (i_rd && i_addr == `OFS_OSC_CONTROL &&
    o_clk_mux_sel != 3'h1 && o_clk_mux_sel != 3'h3 |=> !o_rdata[5]) else $error("lock high in non-pll mode");
  // ********
  // register copies
  // ********
  chk_trim_write: assert property (i_wr && i_addr == `OFS_FAST_RC_TRIM ##1
    !(i_wr && i_addr == `OFS_FAST_RC_TRIM) |=> {10'h000, o_fast_rc_trim_reg} == ($past(i_wdata, 2) & 16'h003f))
    else $error("trim copy wrong");
  chk_div_hold: assert property (!(i_wr && i_addr == `OFS_CLOCK_DIVIDER) [*2]
    |=> $stable(o_clock_divider_reg)) else $error("divider changed without a write");
  chk_sec_bits: assert property (i_wr && i_addr == `OFS_OSC_CONTROL ##1
    !(i_wr && i_addr == `OFS_OSC_CONTROL) |=> o_secondary_osc_run == $past(i_wdata[1], 2) &&
    o_secondary_osc_high_drive == ($past(i_wdata[2], 2) && $past(i_secondary_osc_source, 3)))
    else $error("secondary bits wrong");
  chk_drive_inert: assert property (!i_secondary_osc_source [*4] |-> !o_secondary_osc_high_drive)
    else $error("drive active with digital clock input");
  chk_mask_off: assert property (i_wr && i_addr == `OFS_IRQ_MASK && i_wdata[2:0] == 3'h0 |-> ##[1:3] !o_irq)
    else $error("irq high with mask clear");
  // reset is checked while it is held, so no disable here
  chk_reset_state: assert property (disable iff (1'b0) i_sys_rst |-> !o_irq && o_rdata == 16'h0000 &&
    o_clock_divider_reg == 16'h3100 && o_fast_rc_trim_reg == 6'h00) else $error("reset state wrong");
  cover property (o_irq);
  cover property (i_rd && i_addr == `OFS_IRQ_STATUS ##1 o_rdata[0]);
  cover property ($changed(o_clk_mux_sel));
endmodule : osc_select_ctl_props
bind osc_select_ctl osc_select_ctl_props #(.SETTLE(SETTLE)) osc_select_ctl_props_inst (.i_clk, .i_sys_rst,
  .i_addr, .i_wdata, .i_wr, .i_rd, .i_secondary_osc_source, .o_rdata, .o_irq, .o_clk_mux_sel, .o_secondary_osc_run,
  .o_secondary_osc_high_drive, .o_clock_divider_reg, .o_fast_rc_trim_reg);

// ### verif/oscillator_select_control_tb.sv
// self-checking bench for the oscillator select block
// assumes the analog model on the status pins and a short settle count
`timescale 1ns/1ps
`include "osc_ctl_cfg.svh"
module oscillator_select_control_tb;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] i_boot_source_config = 3'h0;
  logic i_freeze_hw_set = 1'b0;
  logic i_freeze_hw_clr = 1'b0;
  logic fail_inject = 1'b0; // fault request to the model
  logic secondary_osc_xtal = 1'b0; // secondary source: 1 crystal, 0 digital clock
  logic pll_locked, clock_fail, secondary_osc_src, o_irq, o_secondary_osc_run, o_secondary_osc_high_drive;
  logic [15:0] o_rdata, o_clock_divider_reg, rv, v; // rv: last read word
  logic [2:0] o_clk_mux_sel, cur;
  logic [5:0] o_fast_rc_trim_reg;
  logic [1:0] r;
  int fail_count = 0;
  int total_checks = 0;
  always #2 i_clk = ~i_clk;
  osc_select_ctl #(.SETTLE(2)) osc_select_ctl_inst (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_boot_source_config, .i_pll_locked(pll_locked), .i_clock_fail(clock_fail),
    .i_secondary_osc_source(secondary_osc_src), .i_freeze_hw_set, .i_freeze_hw_clr, .o_rdata, .o_irq,
    .o_clk_mux_sel, .o_secondary_osc_run, .o_secondary_osc_high_drive, .o_clock_divider_reg,
    .o_fast_rc_trim_reg);
  osc_analog_model osc_analog_model_inst (.i_clk, .i_mux_sel(o_clk_mux_sel), .i_fail_inject(fail_inject),
    .i_crystal(secondary_osc_xtal),
    .o_pll_locked(pll_locked), .o_clock_fail(clock_fail), .o_secondary_osc_source(secondary_osc_src));
  // ********
  // helpers
  // ********
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [15:0] pll_mode(input logic [2:0] n);
    return {15'h0000, n == 3'h1 || n == 3'h3};
  endfunction : pll_mode
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd
  task automatic reset_and_check;
    i_boot_source_config <= 3'($urandom);
    i_sys_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rd(`OFS_OSC_CONTROL);
    check(rv, {1'b0, i_boot_source_config, 1'b0, i_boot_source_config, 8'h00});
    check(16'(o_clk_mux_sel), 16'(i_boot_source_config));
    rd(`OFS_CLOCK_DIVIDER);
    check(rv, 16'h3100);
    rd(`OFS_FAST_RC_TRIM);
    check(rv, 16'h0000);
  endtask : reset_and_check
  // request a source, poll until the request bit drops
  task automatic switch_to(input logic [2:0] n);
    int k;
    wr(`OFS_OSC_CONTROL, {5'h00, n, 8'h01});
    rd(`OFS_OSC_CONTROL);
    for (k = 0; k < 20 && rv[0] !== 1'b0; k++) rd(`OFS_OSC_CONTROL);
    check({9'h000, rv[14:8]}, {9'h000, n, 1'b0, n});
    check(16'(o_clk_mux_sel), 16'(n));
    repeat (12) @(posedge i_clk);
    rd(`OFS_OSC_CONTROL);
    check(16'(rv[5]), pll_mode(n));
  endtask : switch_to
  task automatic hw_freeze(input logic set_not_clr);
    @(posedge i_clk);
    i_freeze_hw_set <= set_not_clr;
    i_freeze_hw_clr <= ~set_not_clr;
    @(posedge i_clk);
    i_freeze_hw_set <= 1'b0;
    i_freeze_hw_clr <= 1'b0;
    rd(`OFS_OSC_CONTROL);
    check(16'(rv[7]), 16'(set_not_clr));
  endtask : hw_freeze
  // ********
  // main sequence
  // ********
  initial begin
    void'($urandom(32'h21b4_0225));
    reset_and_check();
    wr(`OFS_IRQ_MASK, 16'h0001);
    // every source code, with the done interrupt masked and unmasked
    for (int i = 0; i < 8; i++) begin
      switch_to(3'(i));
      check(16'(o_irq), 16'h0001);
      wr(`OFS_IRQ_MASK, 16'h0000);
      repeat (3) @(posedge i_clk);
      check(16'(o_irq), 16'h0000);
      wr(`OFS_IRQ_MASK, 16'h0001);
      rd(`OFS_IRQ_STATUS);
      check(rv & 16'h0001, 16'h0001);
      repeat (3) @(posedge i_clk);
      check(16'(o_irq), 16'h0000);
    end
    // clock fail: hardware sets, software only clears
    @(posedge i_clk);
    fail_inject <= 1'b1;
    repeat (8) @(posedge i_clk);
    fail_inject <= 1'b0;
    rd(`OFS_OSC_CONTROL);
    check(16'(rv[3]), 16'h0001);
    repeat (4) @(posedge i_clk);
    wr(`OFS_OSC_CONTROL, {5'h00, rv[14:12], 8'h00});
    rd(`OFS_OSC_CONTROL);
    check(16'(rv[3]), 16'h0000);
    // reserved bits and fail bit ignore writes; drive against crystal and digital input
    for (int j = 0; j < 4; j++) begin
      secondary_osc_xtal <= 1'(j);
      r = {1'(j >> 1), 1'($urandom)};
      wr(`OFS_OSC_CONTROL, 16'h8808 | {13'h0000, r, 1'b0});
      rd(`OFS_OSC_CONTROL);
      check(rv & 16'h880e, {13'h0000, r, 1'b0});
      check({14'h0000, o_secondary_osc_high_drive, o_secondary_osc_run}, {14'h0000, r[1] & secondary_osc_xtal, r[0]});
    end
    // freeze: software sets only, switch refused while frozen
    wr(`OFS_OSC_CONTROL, 16'h0080);
    wr(`OFS_OSC_CONTROL, 16'h0000);
    rd(`OFS_OSC_CONTROL);
    check(16'(rv[7]), 16'h0001);
    cur = rv[14:12];
    wr(`OFS_OSC_CONTROL, {5'h00, ~cur, 8'h01});
    repeat (20) @(posedge i_clk);
    rd(`OFS_OSC_CONTROL);
    check({12'h000, rv[14:12], rv[0]}, {12'h000, cur, 1'b0});
    hw_freeze(1'b0);
    hw_freeze(1'b1);
    hw_freeze(1'b0);
    // trim and divider, all ones first
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'hffff : 16'($urandom);
      wr(`OFS_FAST_RC_TRIM, v);
      rd(`OFS_FAST_RC_TRIM);
      check(rv, {10'h000, v[5:0]});
      check(16'(o_fast_rc_trim_reg), 16'(v[5:0]));
      wr(`OFS_CLOCK_DIVIDER, v);
      rd(`OFS_CLOCK_DIVIDER);
      check(rv, v);
      check(o_clock_divider_reg, v);
    end
    for (int a = 5; a < 16; a++) begin
      rd(4'(a));
      check(rv, 16'h0000);
    end
    reset_and_check(); // second reset in mid-run
    end_of_test();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    end_of_test();
  end
endmodule : oscillator_select_control_tb
